//--- rcv_consts.svh
// register offsets, reset values and field positions of the reset-cause block
`ifndef RCV_CONSTS_SVH
`define RCV_CONSTS_SVH

// -----------------------------------------------------------------------------
// register byte offsets and decoded selects
// -----------------------------------------------------------------------------
`define RCV_OFF_CAUSE_A  8'h00
`define RCV_OFF_CAUSE_B  8'h04
`define RCV_OFF_IRQ_STAT 8'h08
`define RCV_OFF_IRQ_MASK 8'h0C
`define RCV_OFF_CTRL     8'h10
`define RCV_SEL_NONE     3'h0
`define RCV_SEL_CAUSE_A  3'h1
`define RCV_SEL_CAUSE_B  3'h2
`define RCV_SEL_IRQ_STAT 3'h3
`define RCV_SEL_IRQ_MASK 3'h4
`define RCV_SEL_CTRL     3'h5

// -----------------------------------------------------------------------------
// reset values and field layout
// -----------------------------------------------------------------------------
`define RCV_A_RESET      8'h3D
`define RCV_A_ACTIVE     8'hC0
`define RCV_B_MEMORY_VIOLATION_FLAG       1
`define RCV_MEMORY_VIOLATION_FLAG_RESET   1'h1
`define RCV_ST_MEMORY_VIOLATION_FLAG      8
`define RCV_ST_RESET     9'h000
`define RCV_MASK_RESET   9'h000
`define RCV_CTRL_SAF     0
`define RCV_CTRL_RESET   1'h0
`define RCV_RESP_OKAY    2'h0
`define RCV_RESP_SLVERR  2'h2

// -----------------------------------------------------------------------------
// default execution area bounds
// -----------------------------------------------------------------------------
`define RCV_FLASH_TOP    15'h07FF
`define RCV_SAF_LO       15'h0780
`define RCV_SAF_HI       15'h07FF

`endif

//--- rcv_cpu_model.sv
// model of the cpu fetch and execute pipeline feeding the execute path
`timescale 1ns/10ps

module rcv_cpu_model (
    input  wire logic          clk,
    output rcv_pkg::rcv_exec_s exec,
    output logic               int_req
);
    import rcv_pkg::*;

    initial begin
        exec    = '0;
        int_req = 1'b0;
    end

    // ---------------------------------------------------------------------
    // one instruction slot per call
    // ---------------------------------------------------------------------
    task automatic fetch(input rcv_pc_t a, input logic v);
        exec <= '{prefetch: ~v, valid: v, addr: a};
        @(posedge clk);
        // released slot shows the inverted address so a stale value is never taken for live
        exec <= '{prefetch: 1'b0, valid: 1'b0, addr: ~a};
    endtask

    task automatic set_int(input logic v);
        int_req <= v;
    endtask
endmodule

//--- rcv_exec_check.sv
// execution area check: flags execution of an instruction from an invalid address
`timescale 1ns/10ps
`include "rcv_consts.svh"

module rcv_exec_check #(
    parameter rcv_pkg::rcv_pc_t FLASH_TOP = `RCV_FLASH_TOP,
    parameter rcv_pkg::rcv_pc_t SAF_LO    = `RCV_SAF_LO,
    parameter rcv_pkg::rcv_pc_t SAF_HI    = `RCV_SAF_HI
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire rcv_pkg::rcv_exec_s  exec,
    input  wire logic                saf_en,
    output logic                     hit,
    output logic                     viol
);
    import rcv_pkg::*;

    logic in_flash;
    logic in_saf;
    logic viol_reg;

    // bounds come from the implemented flash size
    assign in_flash = (exec.addr <= FLASH_TOP);
    assign in_saf   = saf_en && (exec.addr >= SAF_LO) && (exec.addr <= SAF_HI);
    // prefetch alone never counts, only a real execute
    assign hit      = exec.valid && (!in_flash || in_saf);
    assign viol     = viol_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            viol_reg <= 1'b0;
        end else begin
            viol_reg <= hit;
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    property p_out_of_flash;
        @(posedge clk) disable iff (!rst_n)
        (exec.valid && exec.addr > FLASH_TOP) |=> viol;
    endproperty
    a_out_of_flash: assert property (p_out_of_flash) else $error("execute beyond flash gave no violation");

    property p_saf_exec;
        @(posedge clk) disable iff (!rst_n)
        (exec.valid && saf_en && exec.addr >= SAF_LO && exec.addr <= SAF_HI) |=> viol;
    endproperty
    a_saf_exec: assert property (p_saf_exec) else $error("execute in storage area gave no violation");

    property p_prefetch_only;
        @(posedge clk) disable iff (!rst_n)
        (!exec.valid) |=> !viol;
    endproperty
    a_prefetch_only: assert property (p_prefetch_only) else $error("violation without an execute");
endmodule

//--- rcv_pkg.sv
// types shared by the reset-cause block
package rcv_pkg;
    typedef logic [14:0] rcv_pc_t;
    typedef logic [2:0]  rcv_sel_t;

    typedef struct packed {
        logic    prefetch;
        logic    valid;
        rcv_pc_t addr;
    } rcv_exec_s;

    // bit order matches the cause register a layout, bit 7 first
    typedef struct packed {
        logic stack_over;
        logic stack_under;
        logic wdt_window;
        logic wdt_timeout;
        logic pin_reset;
        logic reset_instr;
        logic power_on;
        logic brown_out;
    } rcv_cause_s;
endpackage

//--- rcv_reset_cause.sv
// reset-cause flags, execution violation reset and AXI4-Lite register access
//
// How it works
// - executing from outside the valid flash area raises a reset request
// - with the storage area enabled, executing inside it also raises one
// - a fetch that is only prefetched and never executed raises nothing
// - violation acts at once and drops any interrupt request that same cycle
// - a violation resets and drives the active-low memory violation flag low
// - separate sticky flags for each of the nine reset causes
// - each reset updates only its own flag, others keep their value
// - hardware never returns a flag to inactive, software does that
// - software may set flags active; stored and readable, no reset follows
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "rcv_consts.svh"

module rcv_reset_cause #(
    parameter rcv_pkg::rcv_pc_t FLASH_TOP = `RCV_FLASH_TOP,
    parameter rcv_pkg::rcv_pc_t SAF_LO    = `RCV_SAF_LO,
    parameter rcv_pkg::rcv_pc_t SAF_HI    = `RCV_SAF_HI
) (
    input  wire logic                SYS_CLK,
    input  wire logic                RESET_N,
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic [2:0]          S_AXI_AWPROT,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic [2:0]          S_AXI_ARPROT,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    input  wire rcv_pkg::rcv_exec_s  EXEC,
    input  wire rcv_pkg::rcv_cause_s CAUSE_EVENT,
    input  wire logic                INT_REQ,
    output logic                     INT_TO_CPU,
    output logic                     VIOL_RESET,
    output logic                     IRQ
);
    import rcv_pkg::*;

    localparam logic [7:0] A_ACTIVE = `RCV_A_ACTIVE;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic rcv_sel_t decode(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        case (word)
            `RCV_OFF_CAUSE_A:  decode = `RCV_SEL_CAUSE_A;
            `RCV_OFF_CAUSE_B:  decode = `RCV_SEL_CAUSE_B;
            `RCV_OFF_IRQ_STAT: decode = `RCV_SEL_IRQ_STAT;
            `RCV_OFF_IRQ_MASK: decode = `RCV_SEL_IRQ_MASK;
            `RCV_OFF_CTRL:     decode = `RCV_SEL_CTRL;
            default:           decode = `RCV_SEL_NONE;
        endcase
    endfunction

    // byte strobes widened to a bit mask of the low two lanes
    function automatic logic [15:0] lanes(input logic [3:0] strb);
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // -------------------------------------------------------------------------
    // bus write path
    // -------------------------------------------------------------------------
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        aw_take;
    logic        w_take;
    logic        wr_fire;
    logic        aw_full_next;
    logic        w_full_next;
    logic        bvalid_next;
    rcv_sel_t    wsel;
    logic [15:0] wmask;
    logic [15:0] wlanes;

    assign aw_take      = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take       = S_AXI_WVALID && S_AXI_WREADY;
    assign wr_fire      = aw_full_reg && w_full_reg && !S_AXI_BVALID;
    assign aw_full_next = wr_fire ? 1'b0 : (aw_full_reg || aw_take);
    assign w_full_next  = wr_fire ? 1'b0 : (w_full_reg || w_take);
    assign bvalid_next  = wr_fire ? 1'b1 : (S_AXI_BVALID && !S_AXI_BREADY);
    assign wsel         = decode(aw_addr_reg);
    assign wlanes       = lanes(w_strb_reg);
    assign wmask        = wlanes & w_data_reg[15:0];

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `RCV_RESP_OKAY;
        end else begin
            aw_full_reg   <= aw_full_next;
            w_full_reg    <= w_full_next;
            S_AXI_AWREADY <= !aw_full_next && !bvalid_next;
            S_AXI_WREADY  <= !w_full_next && !bvalid_next;
            S_AXI_BVALID  <= bvalid_next;
            if (wr_fire) begin
                S_AXI_BRESP <= (wsel == `RCV_SEL_NONE) ? `RCV_RESP_SLVERR : `RCV_RESP_OKAY;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
        end
    end

    // -------------------------------------------------------------------------
    // execution check
    // -------------------------------------------------------------------------
    logic ctrl_saf_reg;
    logic chk_hit;
    logic chk_viol;

    rcv_exec_check #(
        .FLASH_TOP (FLASH_TOP),
        .SAF_LO    (SAF_LO),
        .SAF_HI    (SAF_HI)
    ) u_check (
        .clk    (SYS_CLK),
        .rst_n  (RESET_N),
        .exec   (EXEC),
        .saf_en (ctrl_saf_reg),
        .hit    (chk_hit),
        .viol   (chk_viol)
    );

    assign VIOL_RESET = chk_viol;

    // interrupt pass-through loses the request in the violation cycle
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            INT_TO_CPU <= 1'b0;
        end else begin
            INT_TO_CPU <= INT_REQ && !chk_hit;
        end
    end

    // -------------------------------------------------------------------------
    // reset-cause flags; they only see RESET_N at power-up, so they
    // survive every reset that they record
    // -------------------------------------------------------------------------
    logic [7:0] cause_a_reg;
    logic [7:0] cause_a_next;
    logic       memory_violation_flag_reg;
    logic       memory_violation_flag_next;

    always_comb begin
        cause_a_next = cause_a_reg;
        if (wr_fire && wsel == `RCV_SEL_CAUSE_A) begin
            // stored as written, never acted on
            cause_a_next = (cause_a_reg & ~wlanes[7:0]) | wmask[7:0];
        end
        for (int i = 0; i < 8; i++) begin
            if (CAUSE_EVENT[i]) begin
                cause_a_next[i] = A_ACTIVE[i];
            end
        end
    end

    always_comb begin
        memory_violation_flag_next = memory_violation_flag_reg;
        if (wr_fire && wsel == `RCV_SEL_CAUSE_B && w_strb_reg[0]) begin
            memory_violation_flag_next = w_data_reg[`RCV_B_MEMORY_VIOLATION_FLAG];
        end
        // hardware only ever drives the flag active; event beats the write
        if (chk_viol) begin
            memory_violation_flag_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cause_a_reg <= `RCV_A_RESET;
            memory_violation_flag_reg    <= `RCV_MEMORY_VIOLATION_FLAG_RESET;
        end else begin
            cause_a_reg <= cause_a_next;
            memory_violation_flag_reg    <= memory_violation_flag_next;
        end
    end

    // -------------------------------------------------------------------------
    // control, interrupt status and mask
    // -------------------------------------------------------------------------
    logic [8:0] irq_stat_reg;
    logic [8:0] irq_mask_reg;
    logic [8:0] stat_clr;

    assign stat_clr = (wr_fire && wsel == `RCV_SEL_IRQ_STAT) ? wmask[8:0] : 9'h000;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_reg <= `RCV_ST_RESET;
            irq_mask_reg <= `RCV_MASK_RESET;
            ctrl_saf_reg <= `RCV_CTRL_RESET;
            IRQ          <= 1'b0;
        end else begin
            // a new event in the clearing cycle stays set
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | {chk_viol, CAUSE_EVENT};
            if (wr_fire && wsel == `RCV_SEL_IRQ_MASK) begin
                irq_mask_reg <= (irq_mask_reg & ~wlanes[8:0]) | wmask[8:0];
            end
            if (wr_fire && wsel == `RCV_SEL_CTRL && w_strb_reg[0]) begin
                ctrl_saf_reg <= w_data_reg[`RCV_CTRL_SAF];
            end
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // -------------------------------------------------------------------------
    // bus read path
    // -------------------------------------------------------------------------
    logic        ar_take;
    logic [31:0] rd_word;
    rcv_sel_t    rsel;

    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rsel    = decode(S_AXI_ARADDR);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rsel)
            `RCV_SEL_CAUSE_A:  rd_word[7:0] = cause_a_reg;
            `RCV_SEL_CAUSE_B:  rd_word[`RCV_B_MEMORY_VIOLATION_FLAG] = memory_violation_flag_reg;
            `RCV_SEL_IRQ_STAT: rd_word[8:0] = irq_stat_reg;
            `RCV_SEL_IRQ_MASK: rd_word[8:0] = irq_mask_reg;
            `RCV_SEL_CTRL:     rd_word[`RCV_CTRL_SAF] = ctrl_saf_reg;
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `RCV_RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= (rsel == `RCV_SEL_NONE) ? `RCV_RESP_SLVERR : `RCV_RESP_OKAY;
        end else if (S_AXI_RVALID) begin
            S_AXI_RVALID  <= !S_AXI_RREADY;
            S_AXI_ARREADY <= S_AXI_RREADY;
        end else begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    property p_int_dropped;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (chk_hit && INT_REQ) |=> (!INT_TO_CPU && VIOL_RESET);
    endproperty
    a_int_dropped: assert property (p_int_dropped) else $error("interrupt passed in violation cycle");

    property p_memory_violation_flag_low;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        VIOL_RESET |=> (memory_violation_flag_reg == 1'b0 && irq_stat_reg[`RCV_ST_MEMORY_VIOLATION_FLAG]);
    endproperty
    a_memory_violation_flag_low: assert property (p_memory_violation_flag_low) else $error("violation did not clear memory violation flag");

    property p_stack_over_flag;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        CAUSE_EVENT.stack_over |=> cause_a_reg[7];
    endproperty
    a_stack_over_flag: assert property (p_stack_over_flag) else $error("stack overflow flag not set");

    property p_others_kept;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (VIOL_RESET && CAUSE_EVENT == 8'h00 && !wr_fire) |=> $stable(cause_a_reg);
    endproperty
    a_others_kept: assert property (p_others_kept) else $error("other cause flags changed on violation");

    property p_memory_violation_flag_sticky;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (!memory_violation_flag_reg && !(wr_fire && wsel == `RCV_SEL_CAUSE_B)) |=> !memory_violation_flag_reg;
    endproperty
    a_memory_violation_flag_sticky: assert property (p_memory_violation_flag_sticky) else $error("flag went inactive without software");

    property p_sw_no_reset;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (wr_fire && !chk_hit) |=> !VIOL_RESET;
    endproperty
    a_sw_no_reset: assert property (p_sw_no_reset) else $error("software write caused a reset");

    property p_irq_level;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (|(irq_stat_reg & irq_mask_reg)) |=> IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked status did not raise interrupt");
endmodule

//--- rcv_reset_cause_tb.sv
// self-checking testbench of the reset-cause and execution violation block
`timescale 1ns/10ps

module rcv_reset_cause_tb;
    import rcv_pkg::*;

    logic        sys_clk, reset_n;
    logic [7:0]  aw_addr, ar_addr;
    logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, ar_valid, ar_ready, r_valid;
    logic [31:0] w_data, r_data;
    logic [1:0]  b_resp, r_resp;
    logic        bready, rready;
    logic [3:0]  w_strb;
    rcv_exec_s   exec;
    rcv_cause_s  cause_event;
    logic        int_req, int_to_cpu, viol_reset, irq;
    int          failures, samples_checked;

    // -------------------------------------------------------------------------
    // design and far side
    // -------------------------------------------------------------------------
    rcv_reset_cause #(.FLASH_TOP(15'h0FFF), .SAF_LO(15'h0F00), .SAF_HI(15'h0F7F)) u_dut (
        .SYS_CLK(sys_clk), .RESET_N(reset_n),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(rready),
        .EXEC(exec), .CAUSE_EVENT(cause_event), .INT_REQ(int_req),
        .INT_TO_CPU(int_to_cpu), .VIOL_RESET(viol_reset), .IRQ(irq));

    rcv_cpu_model u_cpu (.clk(sys_clk), .exec(exec), .int_req(int_req));

    // -------------------------------------------------------------------------
    // checking and bus tasks
    // -------------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        aw_addr  <= a;
        w_data   <= d;
        aw_valid <= 1'b1;
        w_valid  <= 1'b1;
        bready   <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
            if (b_valid || n > 40) break;
        end
        r = b_resp;
        // idle edge so the next call never re-raises bready in this time step
        bready <= 1'b0;
        @(posedge sys_clk);
        if (n > 40) failures++;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        ar_addr  <= a;
        ar_valid <= 1'b1;
        rready   <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
            if (r_valid || n > 40) break;
        end
        d = r_data;
        r = r_resp;
        rready <= 1'b0;
        @(posedge sys_clk);
        if (n > 40) failures++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(n, e, d);
        chk("rresp", 32'h0, {30'h0, r});
    endtask

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task automatic t_reset_values;
        rd_chk("cause_a", 8'h00, 32'h3D);
        rd_chk("cause_b", 8'h04, 32'h2);
        rd_chk("status", 8'h08, 32'h0);
        rd_chk("mask", 8'h0C, 32'h0);
        rd_chk("ctrl", 8'h10, 32'h0);
    endtask

    task automatic t_sw_set;
        wr(8'h00, 32'hC0);
        wr(8'h04, 32'h0);
        chk_bit("viol_reset", 1'b0, viol_reset);
        rd_chk("cause_a", 8'h00, 32'hC0);
        rd_chk("cause_b", 8'h04, 32'h0);
        rd_chk("status", 8'h08, 32'h0);
        wr(8'h00, 32'h3F);
        wr(8'h04, 32'h2);
        // only lane 1 enabled: mask bits 7:0 must stay untouched
        w_strb <= 4'h2;
        wr(8'h0C, 32'h1FF);
        w_strb <= 4'hF;
        rd_chk("mask_lane", 8'h0C, 32'h100);
        wr(8'h0C, 32'h0);
        rd_chk("mask_clear", 8'h0C, 32'h0);
    endtask

    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h14, 32'hFFFF_FFFF, r);
        chk("bresp_unmapped", 32'h2, {30'h0, r});
        axi_rd(8'h14, d, r);
        chk("rdata_unmapped", 32'h0, d);
        chk("rresp_unmapped", 32'h2, {30'h0, r});
    endtask

    task automatic run_exec(input rcv_pc_t a, input logic v, input logic storage_area_region, input logic e);
        wr(8'h10, {31'h0, storage_area_region});
        u_cpu.fetch(a, v);
        @(posedge sys_clk);
        chk_bit("viol_reset", e, viol_reset);
        chk_bit("int_to_cpu", ~e, int_to_cpu);
        @(posedge sys_clk);
        chk_bit("viol_pulse", 1'b0, viol_reset);
        rd_chk("cause_b", 8'h04, e ? 32'h0 : 32'h2);
        rd_chk("status", 8'h08, {23'h0, e, 8'h0});
        chk_bit("irq", e, irq);
        wr(8'h08, 32'h100);
        wr(8'h04, 32'h2);
    endtask

    task automatic t_exec;
        wr(8'h0C, 32'h100);
        u_cpu.set_int(1'b1);
        run_exec(15'h1000, 1'b1, 1'b0, 1'b1);
        run_exec(15'h1000, 1'b0, 1'b0, 1'b0);
        run_exec(15'h0FFF, 1'b1, 1'b0, 1'b0);
        run_exec(15'h0F00, 1'b1, 1'b0, 1'b0);
        run_exec(15'h0F00, 1'b1, 1'b1, 1'b1);
        run_exec(15'h0F7F, 1'b1, 1'b1, 1'b1);
        run_exec(15'h0F80, 1'b1, 1'b1, 1'b0);
        run_exec(15'h7FFF, 1'b1, 1'b1, 1'b1);
        u_cpu.set_int(1'b0);
        wr(8'h10, 32'h0);
    endtask

    task automatic t_events;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            e = 8'h3F;
            e[i] = (i >= 6);
            wr(8'h0C, i[0] ? 32'h1 << i : 32'h0);
            cause_event <= 8'h01 << i;
            @(posedge sys_clk);
            cause_event <= '0;
            repeat (10) @(posedge sys_clk);
            rd_chk("cause_a", 8'h00, {24'h0, e});
            rd_chk("status", 8'h08, 32'h1 << i);
            chk_bit("irq", i[0], irq);
            wr(8'h08, 32'h1 << i);
            repeat (2) @(posedge sys_clk);
            chk_bit("irq_clear", 1'b0, irq);
            wr(8'h00, 32'h3F);
        end
        rd_chk("cause_b", 8'h04, 32'h2);
    endtask

    // -------------------------------------------------------------------------
    // clock, reset, sequence and verdict
    // -------------------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // budget well above the roughly five hundred cycles the scenarios need
    initial begin
        #(50 * 30000);
        failures++;
        close_out();
    end

    initial begin
        failures        = 0;
        samples_checked = 0;
        reset_n     = 1'b0;
        aw_addr     = '0;
        ar_addr     = '0;
        aw_valid    = 1'b0;
        w_valid     = 1'b0;
        ar_valid    = 1'b0;
        w_data      = '0;
        bready      = 1'b0;
        rready      = 1'b0;
        w_strb      = 4'hF;
        cause_event = '0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset_values();
        t_sw_set();
        t_unmapped();
        t_exec();
        t_events();
        close_out();
    end
endmodule
